// ===== include/scp_params.svh
// Purpose: Constants of the serial configuration port.
// Assumes: Seven-bit register addresses, eight-bit registers.
// Notes:   Included by bare name; definitions only.
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

`define SCP_NUM_REGS 128
`define SCP_BYTE_LAST 3'h7
`define SCP_BIT_FIRST 3'h0
`define SCP_INSTR_RW_BIT 7
`define SCP_ADDR_MIN 7'h00
`define SCP_ADDR_MAX 7'h7F
`define SCP_ADDR_STEP 7'h01
`define SCP_ADDR_COMM 7'h00
`define SCP_COMM_BIDIR_BIT 7
`define SCP_COMM_LSB_FIRST_BIT 6
`define SCP_ADDR_POWER 7'h01
`define SCP_ADDR_CLKRX 7'h08
`define SCP_ADDR_PLL1 7'h0A
`define SCP_ADDR_PLL2 7'h0C
`define SCP_ADDR_PLL3 7'h0D
`define SCP_ADDR_FTW0 7'h30
`define SCP_ADDR_FTW1 7'h31
`define SCP_ADDR_FTW2 7'h32
`define SCP_ADDR_FTW3 7'h33
`define SCP_ADDR_PHASE0 7'h34
`define SCP_ADDR_PHASE1 7'h35
`define SCP_ADDR_UPDATE 7'h36
`define SCP_UPDATE_BIT 0
`define SCP_RST_ZERO 8'h00
`define SCP_RST_POWER 8'h10
`define SCP_RST_CLKRX 8'h3F
`define SCP_RST_PLL1 8'h40
`define SCP_RST_PLL2 8'hD1
`define SCP_RST_PLL3 8'hD9
`define SCP_SCLK_MAX_MHZ 40

`endif

// ===== include/scp_pkg.sv
// Purpose: Types of the serial configuration port.
// Assumes: Nothing beyond the constants header.
// Notes:   Used by scoped name only.
`default_nettype none

package scp_pkg;
  typedef enum logic {SCP_INSTR, SCP_DATA} scp_phase_t;
  typedef logic [7:0] scp_byte_t;
  typedef logic [6:0] scp_addr_t;
endpackage : scp_pkg

`default_nettype wire

// ===== rtl/scp_serial_config_port.sv
// Purpose: Four-wire serial configuration port with its register file.
// Assumes: SCLK is the link clock and may stop outside frames.
// Notes:   Register file lives on SCLK; writes reach CLK by toggles.
`include "scp_params.svh"
`default_nettype none

module scp_serial_config_port (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDIO_IN,
  output logic SDIO_OUT,
  output logic SDIO_OE_N,
  output logic SERIAL_OUT_PIN_OUT,
  output logic SERIAL_OUT_PIN_OE_N,
  output logic CFG_WR_STROBE,
  output logic [6:0] CFG_WR_ADDR,
  output logic [7:0] CFG_WR_DATA,
  output logic NCO_UPDATE_STROBE,
  output logic [31:0] NCO_TUNING_WORD,
  output logic [15:0] NCO_PHASE_OFFSET
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic scp_pkg::scp_byte_t shift_in(
    input scp_pkg::scp_byte_t cur, input logic bit_in, input logic lsb_first);
    shift_in = lsb_first ? {bit_in, cur[7:1]} : {cur[6:0], bit_in};
  endfunction

  function automatic logic first_out(
    input scp_pkg::scp_byte_t cur, input logic lsb_first);
    first_out = lsb_first ? cur[0] : cur[7];
  endfunction

  function automatic scp_pkg::scp_byte_t shift_out(
    input scp_pkg::scp_byte_t cur, input logic lsb_first);
    shift_out = lsb_first ? {1'b0, cur[7:1]} : {cur[6:0], 1'b0};
  endfunction

  function automatic scp_pkg::scp_byte_t reset_value(
    input scp_pkg::scp_addr_t a);
    unique case (a)
      `SCP_ADDR_POWER: reset_value = `SCP_RST_POWER;
      `SCP_ADDR_CLKRX: reset_value = `SCP_RST_CLKRX;
      `SCP_ADDR_PLL1: reset_value = `SCP_RST_PLL1;
      `SCP_ADDR_PLL2: reset_value = `SCP_RST_PLL2;
      `SCP_ADDR_PLL3: reset_value = `SCP_RST_PLL3;
      default: reset_value = `SCP_RST_ZERO;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic rst_link;
  scp_pkg::scp_phase_t phase;
  logic [2:0] bit_cnt;
  scp_pkg::scp_byte_t rx_shift;
  logic is_read;
  scp_pkg::scp_addr_t addr;
  scp_pkg::scp_byte_t regs [`SCP_NUM_REGS];
  scp_pkg::scp_byte_t tx_shift;
  logic out_bit;
  logic drive_en;
  logic wr_tgl;
  scp_pkg::scp_addr_t wr_addr_hold;
  scp_pkg::scp_byte_t wr_data_hold;
  logic upd_tgl;
  logic [31:0] ftw_active;
  logic [15:0] phase_active;
  logic [2:0] wr_sync;
  logic [2:0] upd_sync;

  wire logic lsb_first = regs[`SCP_ADDR_COMM][`SCP_COMM_LSB_FIRST_BIT];
  wire logic bidir = regs[`SCP_ADDR_COMM][`SCP_COMM_BIDIR_BIT];
  wire scp_pkg::scp_byte_t full_byte = shift_in(rx_shift, SDIO_IN,
    lsb_first);
  wire logic byte_done = (bit_cnt == `SCP_BYTE_LAST);
  wire logic in_data = (phase == scp_pkg::SCP_DATA);
  wire logic data_write = byte_done && in_data && !is_read;
  wire scp_pkg::scp_addr_t next_addr = lsb_first ?
    (addr + `SCP_ADDR_STEP) : (addr - `SCP_ADDR_STEP);
  wire logic held_addr = (addr >= `SCP_ADDR_FTW0) &&
    (addr <= `SCP_ADDR_PHASE1);
  wire logic update_now = data_write && (addr == `SCP_ADDR_UPDATE) &&
    full_byte[`SCP_UPDATE_BIT];
  wire scp_pkg::scp_byte_t tx_cur = (bit_cnt == `SCP_BIT_FIRST) ?
    regs[addr] : tx_shift;
  wire logic wr_event = wr_sync[2] ^ wr_sync[1];
  wire logic upd_event = upd_sync[2] ^ upd_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Reset for the link side, taken from the system clock

  always_ff @(posedge CLK) begin
    rst_link <= RST;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Framing: chip select high clears bit count, phase and shift register mid-byte

  always_ff @(posedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      bit_cnt <= `SCP_BIT_FIRST;
      phase <= scp_pkg::SCP_INSTR;
      rx_shift <= `SCP_RST_ZERO;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_shift <= full_byte;
      if (byte_done) begin
        unique case (phase)
          scp_pkg::SCP_INSTR: phase <= scp_pkg::SCP_DATA;
          scp_pkg::SCP_DATA: phase <= scp_pkg::SCP_DATA;
        endcase
      end
    end
  end

  // Instruction fields survive chip select so no reset constant is needed
  always_ff @(posedge SCLK) begin
    if (byte_done && !in_data) begin
      is_read <= full_byte[`SCP_INSTR_RW_BIT];
      addr <= full_byte[6:0];
    end else if (byte_done) begin
      addr <= next_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and held tuning values

  always_ff @(posedge SCLK or posedge rst_link) begin
    if (rst_link) begin
      for (int i = 0; i < `SCP_NUM_REGS; i++) begin
        regs[i] <= reset_value(7'(i));
      end
      wr_tgl <= 1'b0;
      wr_addr_hold <= `SCP_ADDR_MIN;
      wr_data_hold <= `SCP_RST_ZERO;
      upd_tgl <= 1'b0;
      ftw_active <= 32'h0000_0000;
      phase_active <= 16'h0000;
    end else if (data_write && !CS_N) begin
      regs[addr] <= full_byte;
      if (!held_addr) begin
        wr_tgl <= ~wr_tgl;
        wr_addr_hold <= addr;
        wr_data_hold <= full_byte;
      end
      if (update_now) begin
        ftw_active <= {regs[`SCP_ADDR_FTW3], regs[`SCP_ADDR_FTW2],
          regs[`SCP_ADDR_FTW1], regs[`SCP_ADDR_FTW0]};
        phase_active <= {regs[`SCP_ADDR_PHASE1],
          regs[`SCP_ADDR_PHASE0]};
        upd_tgl <= ~upd_tgl;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, shifted out on the falling edge

  always_ff @(negedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      drive_en <= 1'b0;
      out_bit <= 1'b0;
      tx_shift <= `SCP_RST_ZERO;
    end else begin
      drive_en <= in_data && is_read;
      out_bit <= first_out(tx_cur, lsb_first);
      tx_shift <= shift_out(tx_cur, lsb_first);
    end
  end

  // Enables fall back at once on chip select, not at the next SCLK edge
  assign SDIO_OUT = out_bit;
  assign SERIAL_OUT_PIN_OUT = out_bit;
  assign SDIO_OE_N = !(drive_en && bidir && !CS_N);
  assign SERIAL_OUT_PIN_OE_N = !(drive_en && !bidir && !CS_N);

  ////////////////////////////////////////////////////////////////////////////
  // Crossing to CLK; held words stay stable for at least eight SCLK edges,
  // far longer than the three CLK cycles the capture needs

  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_sync <= 3'h0;
      upd_sync <= 3'h0;
    end else begin
      wr_sync <= {wr_sync[1:0], wr_tgl};
      upd_sync <= {upd_sync[1:0], upd_tgl};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      CFG_WR_STROBE <= 1'b0;
      CFG_WR_ADDR <= `SCP_ADDR_MIN;
      CFG_WR_DATA <= `SCP_RST_ZERO;
    end else begin
      CFG_WR_STROBE <= wr_event;
      if (wr_event) begin
        CFG_WR_ADDR <= wr_addr_hold;
        CFG_WR_DATA <= wr_data_hold;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      NCO_UPDATE_STROBE <= 1'b0;
      NCO_TUNING_WORD <= 32'h0000_0000;
      NCO_PHASE_OFFSET <= 16'h0000;
    end else begin
      NCO_UPDATE_STROBE <= upd_event;
      if (upd_event) begin
        NCO_TUNING_WORD <= ftw_active;
        NCO_PHASE_OFFSET <= phase_active;
      end
    end
  end

endmodule // scp_serial_config_port

`default_nettype wire

// ===== test/scp_serial_config_port_properties.sv
// Purpose: Assertions on the CLK side and pin enables.
// Assumes: Bound to the top module.
// Notes: CS_N is seen only at CLK edges.
`default_nettype none
module scp_props (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CS_N,
  input wire logic SDIO_OE_N,
  input wire logic SERIAL_OUT_PIN_OE_N,
  input wire logic CFG_WR_STROBE,
  input wire logic [6:0] CFG_WR_ADDR,
  input wire logic [7:0] CFG_WR_DATA,
  input wire logic NCO_UPDATE_STROBE,
  input wire logic [31:0] NCO_TUNING_WORD,
  input wire logic [15:0] NCO_PHASE_OFFSET
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);
  sequence s_one(x);
    x ##1 !x;
  endsequence
  property p_float; CS_N |-> SDIO_OE_N && SERIAL_OUT_PIN_OE_N; endproperty
  a_float: assert property (p_float) else $error("pin driven");
  property p_one; !SDIO_OE_N |-> SERIAL_OUT_PIN_OE_N; endproperty
  a_one: assert property (p_one) else $error("both pins");
  property p_wrp; CFG_WR_STROBE |-> s_one(CFG_WR_STROBE); endproperty
  a_wrp: assert property (p_wrp) else $error("long strobe");
  property p_upp; NCO_UPDATE_STROBE |-> s_one(NCO_UPDATE_STROBE); endproperty
  a_upp: assert property (p_upp) else $error("long update");
  property p_held;
    CFG_WR_STROBE |-> !(CFG_WR_ADDR inside {[7'h30:7'h35]});
  endproperty
  a_held: assert property (p_held) else $error("held byte out");
  property p_wrd;
    $changed({CFG_WR_ADDR, CFG_WR_DATA}) |->
      CFG_WR_STROBE || $past(CFG_WR_STROBE);
  endproperty
  a_wrd: assert property (p_wrd) else $error("data moved");
  property p_ftw;
    $changed(NCO_TUNING_WORD) |-> NCO_UPDATE_STROBE || $past(NCO_UPDATE_STROBE);
  endproperty
  a_ftw: assert property (p_ftw) else $error("word moved");
  property p_ph;
    $changed(NCO_PHASE_OFFSET) |-> NCO_UPDATE_STROBE || $past(NCO_UPDATE_STROBE);
  endproperty
  a_ph: assert property (p_ph) else $error("phase moved");
  property p_frm; CFG_WR_STROBE |-> !$past(CS_N, 2); endproperty
  a_frm: assert property (p_frm) else $error("write outside frame");
endmodule // scp_props
bind scp_serial_config_port scp_props chk (.CLK, .RST, .CS_N, .SDIO_OE_N,
  .SERIAL_OUT_PIN_OE_N, .CFG_WR_STROBE, .CFG_WR_ADDR, .CFG_WR_DATA,
  .NCO_UPDATE_STROBE, .NCO_TUNING_WORD, .NCO_PHASE_OFFSET);
`default_nettype wire

// ===== test/scp_host.sv
// Purpose: Host serial master for the configuration port.
// Assumes: SCLK idles low and runs only inside frames, save two stray edges after a cut frame.
// Notes: A released data line shows the inverse of its last value.
`default_nettype none
module scp_host (
  output logic SCLK,
  output logic CS_N,
  output logic SDIO_IN,
  input wire logic SDIO_OUT,
  input wire logic SDIO_OE_N,
  input wire logic SERIAL_OUT_PIN_OUT,
  input wire logic SERIAL_OUT_PIN_OE_N
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv = 1'b0;
  logic pin;
  // Set by the bench to match the pin mode held in the control register
  logic bidir_mode = 1'b0;
  // Shared wire: the port's read drive wins while enabled
  assign SDIO_IN = SDIO_OE_N ? drv : SDIO_OUT;
  // Only the pin of the current mode counts, so a wrong pin reads as x
  assign pin = bidir_mode ? (!SDIO_OE_N ? SDIO_OUT : 1'bx) :
    (!SERIAL_OUT_PIN_OE_N ? SERIAL_OUT_PIN_OUT : 1'bx);
  initial begin
    SCLK = 1'b0;
    CS_N = 1'b1;
  end
  task automatic xfer(input logic [7:0] ins, input logic lsb, input int n,
    input logic [31:0] wd, input int stop, output logic [31:0] rd);
    int i;
    int k;
    rd = 32'h0;
    CS_N = 1'b0;
    for (i = 0; i < 8 * n + 8 && i < stop; i++) begin
      k = lsb ? i % 8 : 7 - i % 8;
      drv = i < 8 ? ins[k] : ins[7] ? ~drv : wd[i - 8 - i % 8 + k];
      #80;
      if (i >= 8) rd[i - 8 - i % 8 + k] = pin;
      SCLK = 1'b1;
      #80;
      SCLK = 1'b0;
    end
    CS_N = 1'b1;
    drv = ~drv;
    // Stray edges while deselected, only when a frame is cut short
    repeat (stop < 99 ? 2 : 0) #40 SCLK = ~SCLK;
    #160;
  endtask
endmodule // scp_host
`default_nettype wire

// ===== test/serial_config_port_tb.sv
// Purpose: Self-checking bench of the serial configuration port.
// Assumes: Host frames start off the CLK edge grid.
// Notes: Strobes are logged on CLK and judged after chosen frames.
`default_nettype none
module serial_config_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  wire SCLK, CS_N, SDIO_IN, SDIO_OUT, SDIO_OE_N, SO, SO_OE_N, WS, US;
  wire [6:0] WA;
  wire [7:0] WD;
  wire [31:0] FTW;
  wire [15:0] PH;
  int mismatches = 0;
  int comparisons = 0;
  int nw = 0;
  int nu = 0;
  logic [6:0] la;
  logic [7:0] ld;
  logic [31:0] r;
  initial begin
    forever #2 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    if (WS === 1'b1) begin
      nw++;
      la = WA;
      ld = WD;
    end
    if (US === 1'b1) nu++;
  end
  scp_host host (.SCLK, .CS_N, .SDIO_IN, .SDIO_OUT, .SDIO_OE_N,
    .SERIAL_OUT_PIN_OUT(SO), .SERIAL_OUT_PIN_OE_N(SO_OE_N));
  scp_serial_config_port dut (.CLK, .RST, .SCLK, .CS_N, .SDIO_IN, .SDIO_OUT,
    .SDIO_OE_N, .SERIAL_OUT_PIN_OUT(SO), .SERIAL_OUT_PIN_OE_N(SO_OE_N),
    .CFG_WR_STROBE(WS), .CFG_WR_ADDR(WA), .CFG_WR_DATA(WD),
    .NCO_UPDATE_STROBE(US), .NCO_TUNING_WORD(FTW), .NCO_PHASE_OFFSET(PH));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic go(input logic [7:0] ins, input logic lsb, input int n,
    input logic [31:0] wd, input int stop = 99);
    @(posedge CLK);
    #1 host.xfer(ins, lsb, n, wd, stop, r);
    chk({30'h0, SDIO_OE_N, SO_OE_N}, 32'h3);
  endtask
  task automatic t_defaults;
    chk(FTW, 32'h0);
    go(8'h81, 1'b0, 3, 32'h0);
    chk(r[23:0], 24'h000010);
    go(8'h8D, 1'b0, 2, 32'h0);
    chk(r[15:0], 16'hD1D9);
    $display("reset defaults done");
  endtask
  task automatic t_write;
    go(8'h05, 1'b0, 2, 32'h5AA5);
    chk({la, ld, nw[16:0]}, {7'h04, 8'h5A, 17'h2});
    go(8'h85, 1'b0, 2, 32'h0);
    chk(r[15:0], 16'h5AA5);
    $display("write readback done");
  endtask
  task automatic t_held;
    go(8'h33, 1'b0, 4, 32'h78563412);
    go(8'h35, 1'b0, 2, 32'hCDAB);
    chk({FTW[15:0], nw[15:0]}, 32'h2);
    go(8'h36, 1'b0, 1, 32'h01);
    chk(FTW, 32'h12345678);
    chk({PH, nu[15:0]}, 32'hABCD0001);
    // A clear update bit must leave the applied word alone
    go(8'h30, 1'b0, 1, 32'hEE);
    go(8'h36, 1'b0, 1, 32'h00);
    chk(FTW, 32'h12345678);
    chk(nu, 32'h1);
    $display("held update done");
  endtask
  task automatic t_abort;
    go(8'h05, 1'b0, 1, 32'hFF, 12);
    go(8'h85, 1'b0, 1, 32'h0);
    chk({r[7:0], nw[7:0]}, 16'hA504);
    $display("abort done");
  endtask
  task automatic t_lsb_bidir;
    go(8'h00, 1'b0, 1, 32'hC0);
    host.bidir_mode = 1'b1;
    go(8'h10, 1'b1, 2, 32'h2211);
    go(8'h90, 1'b1, 2, 32'h0);
    chk(r[15:0], 16'h2211);
    go(8'h00, 1'b1, 1, 32'h0);
    host.bidir_mode = 1'b0;
    go(8'h81, 1'b0, 1, 32'h0);
    chk({r[7:0], nw[7:0]}, 16'h1008);
    $display("lsb bidir done");
  endtask
  initial begin
    repeat (6) @(posedge CLK);
    #1 RST = 1'b0;
    repeat (2) @(posedge CLK);
    t_defaults();
    t_write();
    t_held();
    t_abort();
    t_lsb_bidir();
    results();
  end
endmodule // serial_config_port_tb
`default_nettype wire
